/* File: hw/clk_sel_pkg.sv */
// constants, register map and carrier types for the audio clock selector
// assumes a 10 MHz reference clock and a 32-bit classic wishbone master
package clk_sel_pkg;

  // clock and timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int GATE_S      = 1;               // rate gate time in seconds
  localparam int GATE_CYCLES = CLK_HZ * GATE_S;
  localparam int LOCK_MIN_HZ = 28_000;
  localparam int LOCK_MAX_HZ = 200_000;
  localparam int SS_MAX_HZ   = 48_000;          // single speed ceiling
  localparam int SYNC_TOL_HZ = 2;

  // sources, in cyclic scan order
  localparam int NSRC     = 8;
  localparam int SRC_OPT1 = 0;                  // optical 1..4 are 0..3
  localparam int SRC_OPT4 = 3;
  localparam int SRC_SPDIF = 4;
  localparam int SRC_AES  = 5;
  localparam int SRC_WORD = 6;                  // word_clock_input
  localparam int SRC_INT  = 7;

  // register byte addresses
  localparam logic [7:0] A_CFG      = 8'h00;
  localparam logic [7:0] A_MRATE    = 8'h04;
  localparam logic [7:0] A_DDS_CTRL = 8'h08;
  localparam logic [7:0] A_DDS_BASE = 8'h0c;
  localparam logic [7:0] A_COARSE   = 8'h10;
  localparam logic [7:0] A_FINE     = 8'h14;
  localparam logic [7:0] A_STATUS   = 8'h18;
  localparam logic [7:0] A_SYSRATE  = 8'h1c;
  localparam logic [7:0] A_BOOT     = 8'h20;
  localparam logic [7:0] A_DDS_VAL  = 8'h24;
  localparam logic [7:0] A_MEAS0    = 8'h40;    // + 4 * source index

  // spdif input selections
  localparam logic [1:0] SPI_COAX = 2'h0;
  localparam logic [1:0] SPI_OPT4 = 2'h1;
  localparam logic [1:0] SPI_EXP  = 2'h2;

  // dds presets
  localparam logic [2:0] PRE_NONE   = 3'h0;
  localparam logic [2:0] PRE_UP01   = 3'h1;
  localparam logic [2:0] PRE_DN01   = 3'h2;
  localparam logic [2:0] PRE_UP4    = 3'h3;
  localparam logic [2:0] PRE_DN4    = 3'h4;
  localparam int PRE01_DIV = 1000;              // 0.1 percent
  localparam int PRE4_DIV  = 25;                // 4 percent

  typedef logic [19:0] rate_t;
  localparam rate_t RATE_RST = 20'h0bb80;       // 48000 Hz

  typedef struct packed {
    logic       auto_mode;    // 1 = automatic_slave_mode, 0 = master
    logic [2:0] pref_ref;
    logic       single_speed;
    logic [1:0] spdif_in_sel;
    logic       opt4_spdif;   // optical 4 output carries spdif
    logic       exp1_sel;     // optical 1 data from expansion_input_one
    logic       exp2_sel;     // optical 2 data from expansion_input_two
  } cfg_t;
  localparam cfg_t CFG_RST = '0;

  typedef struct packed {
    logic       enable;
    logic [1:0] mult;         // 0 single, 1 double, 2 quad
    logic       coarse_en;
    logic       fine_en;
    logic [2:0] preset;
  } dds_cfg_t;
  localparam dds_cfg_t DDS_RST = '0;

  typedef enum logic [1:0] {
    LK_NONE = 2'h0,
    LK_LOCK = 2'h1,
    LK_SYNC = 2'h2
  } lock_t;

  typedef enum logic [1:0] {
    ST_MASTER = 2'b01,
    ST_SLAVE  = 2'b10
  } clk_state_t;

endpackage : clk_sel_pkg

/* File: hw/audio_clock_source_selector.sv */
// clock source selection, rate measurement, synthesizer and io routing
// assumes all inputs synchronous to ref_clk; src_edge is one pulse per frame

// Summary of operation
// - two modes: master on internal clock, or automatic slave mode.
// - each source reports none, lock or sync.
// - each source's sample rate is measured and readable.
// - preferred reference without signal makes selection move to another source.
// - candidates are optical 1-4, aes, spdif, word clock, internal sync.
// - word clock equals rate; single speed halves it above 48 kHz and quarters it above 96 kHz.
// - status shows master or slave, current source and rate.
// - spdif always on coax; also on optical 4 when so selected.
// - spdif input from coax, optical 4 or expansion header.
// - optical 1 data may come from expansion input one.
// - optical 2 data may come from expansion input two.
// - settings restored from nonvolatile store at power-on, with master rate.
// - host writes take effect at once, no commit.
// - synthesizer settings act only in master mode; host selects it first.
// - synth rate is base plus active adjustment, times multiplier.
// - coarse and fine adjustments work in 1 Hz steps.
// - synth enable gates all synthesizer parameters.
// - presets give 0.1 and 4 percent pull-up and pull-down.
// - after failed programming, boot from backup image at next cold start.
// - lost reference with no other valid input returns to master immediately.
// - lock accepted for any rate between 28 and 200 kHz.
module audio_clock_source_selector #(
  parameter int GATE_CYCLES = clk_sel_pkg::GATE_CYCLES
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   arst_n,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  // source status
  input  wire logic [7:0]             src_valid,
  input  wire logic [7:0]             src_edge,
  // nonvolatile settings store
  input  wire logic                   nv_valid,
  input  wire clk_sel_pkg::cfg_t      nv_cfg,
  input  wire clk_sel_pkg::rate_t     nv_rate,
  input  wire logic                   prog_failed,
  output clk_sel_pkg::cfg_t           cfg,
  output clk_sel_pkg::rate_t          mrate,
  output logic                        boot_backup,
  // clock outputs
  output logic                        frame_tick,
  output logic                        word_clock_tick,
  // digital io routing
  input  wire logic                   spdif_tx,
  input  wire logic                   opt4_adat_tx,
  input  wire logic                   spdif_coax_rx,
  input  wire logic                   opt_rx1,
  input  wire logic                   opt_rx2,
  input  wire logic                   opt_rx4,
  input  wire logic                   expansion_input_one,
  input  wire logic                   expansion_input_two,
  output logic                        spdif_coax_out,
  output logic                        opt4_out,
  output logic                        spdif_rx,
  output logic                        adat1_rx,
  output logic                        adat2_rx
);

  localparam int NSRC = clk_sel_pkg::NSRC;

  // the gate counter is 28 bits wide; a longer gate cannot be counted
  if (GATE_CYCLES < 1 || GATE_CYCLES > 32'h0fffffff)
  begin : g_gate_check
    $error("GATE_CYCLES out of range");
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  clk_sel_pkg::dds_cfg_t frequency_synthesizer;
  logic [17:0]           dds_base;
  logic signed [15:0]    coarse;
  logic signed [15:0]    fine;
  logic                  restored;
  clk_sel_pkg::clk_state_t state;
  logic [2:0]            cur_src;
  clk_sel_pkg::rate_t    sys_rate;
  clk_sel_pkg::rate_t    meas [NSRC];
  clk_sel_pkg::lock_t    lock [NSRC];
  logic [NSRC-1:0]       locked;
  logic [27:0]           gate_cnt;
  logic                  gate_end;
  logic [23:0]           nco;
  logic [1:0]            wc_cnt;
  logic [1:0]            wc_div;

  // bus decode: one access answered per request, ack drops the next cycle
  logic bus_req;
  logic bus_wr;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // write side: settings take effect at the acknowledged edge itself
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg      <= clk_sel_pkg::CFG_RST;
      mrate    <= clk_sel_pkg::RATE_RST;
      restored <= 1'b0;
    end
    else if (!restored)
    begin
      // first edge after release restores the stored state
      restored <= 1'b1;
      if (nv_valid)
      begin
        cfg   <= nv_cfg;
        mrate <= nv_rate;
      end
    end
    else if (bus_wr && wb_sel_i[0])
    begin
      if (wb_adr_i == clk_sel_pkg::A_CFG && wb_sel_i[1])
        cfg <= clk_sel_pkg::cfg_t'(wb_dat_i[9:0]);
      else if (wb_adr_i == clk_sel_pkg::A_MRATE && wb_sel_i[2:1] == 2'h3)
        mrate <= wb_dat_i[19:0];
    end
  end

  // synthesizer settings; written directly, no staging
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frequency_synthesizer      <= clk_sel_pkg::DDS_RST;
      dds_base <= 18'(clk_sel_pkg::RATE_RST);
      coarse   <= 16'sh0000;
      fine     <= 16'sh0000;
    end
    else if (bus_wr && wb_sel_i[0])
    begin
      case (wb_adr_i)
        clk_sel_pkg::A_DDS_CTRL: frequency_synthesizer <= clk_sel_pkg::dds_cfg_t'(wb_dat_i[7:0]);
        clk_sel_pkg::A_DDS_BASE: dds_base <= wb_dat_i[17:0];
        clk_sel_pkg::A_COARSE:   coarse <= wb_dat_i[15:0]; // 1 Hz lsb
        clk_sel_pkg::A_FINE:     fine <= wb_dat_i[15:0];
        default: ;
      endcase
    end
  end

  // boot image choice is taken once per cold start, after reset release
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      boot_backup <= 1'b0;
    else if (!restored)
      boot_backup <= prog_failed;
  end

  // synthesizer rate: (base + preset + active offsets) * multiplier
  logic signed [31:0] dds_sum;
  logic signed [31:0] dds_rate;
  always_comb
  begin
    dds_sum = 32'(signed'({14'h0, dds_base}));
    case (frequency_synthesizer.preset)
      clk_sel_pkg::PRE_UP01: dds_sum = dds_sum + dds_sum / clk_sel_pkg::PRE01_DIV;
      clk_sel_pkg::PRE_DN01: dds_sum = dds_sum - dds_sum / clk_sel_pkg::PRE01_DIV;
      clk_sel_pkg::PRE_UP4:  dds_sum = dds_sum + dds_sum / clk_sel_pkg::PRE4_DIV;
      clk_sel_pkg::PRE_DN4:  dds_sum = dds_sum - dds_sum / clk_sel_pkg::PRE4_DIV;
      default: ;
    endcase
    // a fader that is not active contributes nothing
    if (frequency_synthesizer.coarse_en)
      dds_sum = dds_sum + 32'(coarse);
    if (frequency_synthesizer.fine_en)
      dds_sum = dds_sum + 32'(fine);
    if (dds_sum < 0)
      dds_sum = 32'sh0;
    case (frequency_synthesizer.mult)
      2'h1:    dds_rate = dds_sum <<< 1;
      2'h2:    dds_rate = dds_sum <<< 2;
      default: dds_rate = dds_sum;
    endcase
    if (dds_rate > 32'sh000fffff)
      dds_rate = 32'sh000fffff;
  end

  // internal rate: synthesizer only when enabled and in master mode
  clk_sel_pkg::rate_t int_rate;
  assign int_rate = (frequency_synthesizer.enable && !cfg.auto_mode) ?
                    dds_rate[19:0] : mrate;

  // shared measurement gate
  assign gate_end = (gate_cnt == 28'(GATE_CYCLES - 1));
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      gate_cnt <= 28'h0;
    else
      gate_cnt <= gate_end ? 28'h0 : gate_cnt + 28'h1;
  end

  // per source edge count over the gate, plus lock and sync state
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      clk_sel_pkg::rate_t cnt;
      logic [20:0] diff;
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cnt     <= '0;
          meas[g] <= '0;
        end
        else if (gate_end)
        begin
          meas[g] <= cnt + 20'(src_edge[g]);
          cnt     <= '0;
        end
        else if (src_edge[g] && cnt != 20'hfffff)
          cnt <= cnt + 20'h1;
      end
      // off-standard rates lock too, anywhere inside the window
      assign locked[g] = src_valid[g] &&
        meas[g] >= 20'(clk_sel_pkg::LOCK_MIN_HZ) &&
        meas[g] <= 20'(clk_sel_pkg::LOCK_MAX_HZ);
      assign diff = (meas[g] > sys_rate) ? 21'(meas[g] - sys_rate)
                                         : 21'(sys_rate - meas[g]);
      always_comb
      begin
        if (!locked[g])
          lock[g] = clk_sel_pkg::LK_NONE;
        else if (diff <= 21'(clk_sel_pkg::SYNC_TOL_HZ))
          lock[g] = clk_sel_pkg::LK_SYNC;
        else
          lock[g] = clk_sel_pkg::LK_LOCK;
      end
    end
  endgenerate

  // preferred first, then cyclic scan; all eight sources are candidates
  logic       found;
  logic [2:0] pick;
  always_comb
  begin
    logic [2:0] idx;
    idx   = cfg.pref_ref;
    found = 1'b0;
    pick  = cfg.pref_ref;
    for (int i = 0; i < NSRC; i++)
    begin
      idx = cfg.pref_ref + 3'(i);
      if (!found && locked[idx])
      begin
        found = 1'b1;
        pick  = idx;
      end
    end
  end

  // clock state: loss of every reference falls straight back to master
  clk_sel_pkg::clk_state_t next_state;
  always_comb
  begin
    case (state)
      clk_sel_pkg::ST_MASTER:
        next_state = (cfg.auto_mode && found) ? clk_sel_pkg::ST_SLAVE
                                              : clk_sel_pkg::ST_MASTER;
      clk_sel_pkg::ST_SLAVE:
        next_state = (cfg.auto_mode && found) ? clk_sel_pkg::ST_SLAVE
                                              : clk_sel_pkg::ST_MASTER;
      default:
        next_state = clk_sel_pkg::ST_MASTER;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= clk_sel_pkg::ST_MASTER;
      cur_src  <= 3'h0;
      sys_rate <= clk_sel_pkg::RATE_RST;
    end
    else
    begin
      state   <= next_state;
      cur_src <= pick;
      sys_rate <= (next_state == clk_sel_pkg::ST_SLAVE) ? meas[pick]
                                                        : int_rate;
    end
  end

  // frame tick: follow the reference edge as slave, else run the nco
  logic [24:0] nco_sum;
  assign nco_sum = 25'(nco) + 25'(sys_rate);
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nco        <= 24'h0;
      frame_tick <= 1'b0;
    end
    else if (state == clk_sel_pkg::ST_SLAVE)
    begin
      nco        <= 24'h0;
      frame_tick <= src_edge[cur_src];
    end
    else if (nco_sum >= 25'(clk_sel_pkg::CLK_HZ))
    begin
      nco        <= 24'(nco_sum - 25'(clk_sel_pkg::CLK_HZ));
      frame_tick <= 1'b1;
    end
    else
    begin
      nco        <= nco_sum[23:0];
      frame_tick <= 1'b0;
    end
  end

  // word clock: one tick per frame, or in single speed one per 2 frames above 48 kHz, one per 4 above 96 kHz
  always_comb
  begin
    if (!cfg.single_speed || sys_rate <= 20'(clk_sel_pkg::SS_MAX_HZ))
      wc_div = 2'h0;
    else if (sys_rate <= 20'(2 * clk_sel_pkg::SS_MAX_HZ))
      wc_div = 2'h1;
    else
      wc_div = 2'h3;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wc_cnt          <= 2'h0;
      word_clock_tick <= 1'b0;
    end
    else if (frame_tick)
    begin
      wc_cnt          <= (wc_cnt >= wc_div) ? 2'h0 : wc_cnt + 2'h1;
      word_clock_tick <= (wc_cnt >= wc_div);
    end
    else
      word_clock_tick <= 1'b0;
  end

  // io routing, registered so every output comes from a flop
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      spdif_coax_out <= 1'b0;
      opt4_out       <= 1'b0;
      spdif_rx       <= 1'b0;
      adat1_rx       <= 1'b0;
      adat2_rx       <= 1'b0;
    end
    else
    begin
      spdif_coax_out <= spdif_tx;
      opt4_out       <= cfg.opt4_spdif ? spdif_tx : opt4_adat_tx;
      case (cfg.spdif_in_sel)
        clk_sel_pkg::SPI_OPT4: spdif_rx <= opt_rx4;
        clk_sel_pkg::SPI_EXP:  spdif_rx <= expansion_input_one;
        default:               spdif_rx <= spdif_coax_rx;
      endcase
      adat1_rx <= cfg.exp1_sel ? expansion_input_one : opt_rx1;
      adat2_rx <= cfg.exp2_sel ? expansion_input_two : opt_rx2;
    end
  end

  // read mux; unmapped addresses read as zero
  logic [31:0] rd;
  always_comb
  begin
    rd = 32'h0;
    case (wb_adr_i)
      clk_sel_pkg::A_CFG:      rd = {22'h0, cfg};
      clk_sel_pkg::A_MRATE:    rd = {12'h0, mrate};
      clk_sel_pkg::A_DDS_CTRL: rd = {24'h0, frequency_synthesizer};
      clk_sel_pkg::A_DDS_BASE: rd = {14'h0, dds_base};
      clk_sel_pkg::A_COARSE:   rd = {16'h0, coarse};
      clk_sel_pkg::A_FINE:     rd = {16'h0, fine};
      clk_sel_pkg::A_STATUS:
        rd = {lock[7], lock[6], lock[5], lock[4], lock[3], lock[2],
              lock[1], lock[0], 11'h0, cur_src, state};
      clk_sel_pkg::A_SYSRATE:  rd = {12'h0, sys_rate};
      clk_sel_pkg::A_BOOT:     rd = {31'h0, boot_backup};
      clk_sel_pkg::A_DDS_VAL:  rd = {12'h0, dds_rate[19:0]};
      default:
        if (wb_adr_i[7:5] == 3'h2 && wb_adr_i[1:0] == 2'h0)
          rd = {12'h0, meas[wb_adr_i[4:2]]};
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      wb_dat_o <= 32'h0;
    else if (bus_req && !wb_we_i)
      wb_dat_o <= rd;
  end

  // checks
  chk_cfg_write_now: assert property (
    restored && bus_wr && wb_adr_i == clk_sel_pkg::A_CFG &&
    wb_sel_i[1:0] == 2'h3
    |=> cfg == $past(wb_dat_i[9:0]))
    else $error("config write not applied at once");
  chk_master_mode_set: assert property (
    !cfg.auto_mode |=> state == clk_sel_pkg::ST_MASTER)
    else $error("master setting did not force master state");
  chk_no_ref_master: assert property (
    locked == '0 |=> state == clk_sel_pkg::ST_MASTER)
    else $error("no valid input but not master");
  chk_pref_ref_wins: assert property (
    cfg.auto_mode && locked[cfg.pref_ref] |=>
    state == clk_sel_pkg::ST_SLAVE && cur_src == $past(cfg.pref_ref))
    else $error("preferred locked source not selected");
  chk_dds_gate_off: assert property (
    !frequency_synthesizer.enable && $stable(mrate) && state == clk_sel_pkg::ST_MASTER
    ##1 state == clk_sel_pkg::ST_MASTER |-> sys_rate == $past(mrate))
    else $error("synth parameters leaked while disabled");
  chk_coax_follows: assert property (
    ##1 spdif_coax_out == $past(spdif_tx))
    else $error("coax spdif not driven");
  chk_adat1_route: assert property (
    cfg.exp1_sel |=> adat1_rx == $past(expansion_input_one))
    else $error("optical 1 not taken from expansion input");
  chk_lock_window: assert property (
    lock[0] != clk_sel_pkg::LK_NONE |->
    meas[0] >= 20'(clk_sel_pkg::LOCK_MIN_HZ) &&
    meas[0] <= 20'(clk_sel_pkg::LOCK_MAX_HZ))
    else $error("lock reported outside rate window");
  chk_wc_halved: assert property (
    cfg.single_speed && sys_rate == 20'h17700 && frame_tick && wc_cnt == 2'h0
    |=> !word_clock_tick)
    else $error("word clock not divided at double speed");

  cov_slave_entered: cover property (
    state == clk_sel_pkg::ST_MASTER ##1 state == clk_sel_pkg::ST_SLAVE);
  cov_fallback_used: cover property (
    state == clk_sel_pkg::ST_SLAVE && cur_src != cfg.pref_ref);
  cov_dds_active: cover property (
    frequency_synthesizer.enable && state == clk_sel_pkg::ST_MASTER && frequency_synthesizer.coarse_en);

endmodule : audio_clock_source_selector

/* File: test/src_model.sv */
// partner model: the eight clock-capable digital inputs of the card
// assumes the bench enables each source; frame edges at fixed periods
module src_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // control from the bench
  input  wire logic [7:0] en,
  // towards the card
  output logic      [7:0] src_valid,
  output logic      [7:0] src_edge
);
  timeunit 1ns;
  timeprecision 1ns;

  // periods divide the 30000-cycle bench gate, so any gate holds an exact
  // count; source 0 pulses every cycle so that it lands in the lock window
  localparam int PER [8] = '{1, 4, 5, 8, 10, 20, 25, 40};
  int cnt [8];

  // a source without signal gives no frame edges at all
  assign src_valid = en;

  // one frame pulse per period on each live source
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!arst_n || !en[i])
      begin
        cnt[i]      <= 0;
        src_edge[i] <= 1'b0;
      end
      else
      begin
        cnt[i]      <= (cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
        src_edge[i] <= (cnt[i] == PER[i] - 1);
      end
    end
  end
endmodule : src_model

/* File: test/tb.sv */
// self-checking bench for the audio clock source selector
// assumes a classic wishbone slave and the source model beside it
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int GATE = 30000; // just long enough for source 0 to lock
  localparam int PER [8] = '{1, 4, 5, 8, 10, 20, 25, 40};
  localparam logic [9:0] RCFG [11] = '{10'h000, 10'h004, 10'h000,
    10'h008, 10'h010, 10'h002, 10'h000, 10'h002, 10'h001, 10'h000, 10'h001};
  localparam logic [7:0] RIO [11] = '{8'h80, 8'h80, 8'h20, 8'h04, 8'h02,
    8'h02, 8'h10, 8'h10, 8'h01, 8'h08, 8'h08};
  localparam logic [4:0] REXP [11] = '{5'h10, 5'h18, 5'h04, 5'h04, 5'h04,
    5'h02, 5'h02, 5'h00, 5'h01, 5'h01, 5'h00};
  localparam logic [7:0] DCTL [6] = '{8'h50, 8'h80, 8'ha0, 8'hc0, 8'h90,
    8'h88};
  localparam int DEXP [6] = '{32000, 44100, 88200, 176400, 44105, 44097};
  localparam int PEXP [4] = '{48048, 47952, 49920, 46080};

  logic               ref_clk;
  logic               arst_n;
  logic               wb_cyc_i;
  logic               wb_stb_i;
  logic               wb_we_i;
  logic [7:0]         wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i;
  logic               wb_ack_o;
  logic [31:0]        wb_dat_o;
  logic [7:0]         en;
  logic [7:0]         src_valid;
  logic [7:0]         src_edge;
  logic               nv_valid;
  clk_sel_pkg::cfg_t  nv_cfg;
  clk_sel_pkg::rate_t nv_rate;
  logic               prog_failed;
  clk_sel_pkg::cfg_t  cfg;
  clk_sel_pkg::rate_t mrate;
  logic               boot_backup;
  logic               ft;
  logic               wt;
  logic [7:0]         io;
  wire  [4:0]         ro;
  logic [31:0]        q;
  int                 fail_count;
  int                 n_tests;

  audio_clock_source_selector #(.GATE_CYCLES(GATE)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .src_valid(src_valid), .src_edge(src_edge),
    .nv_valid(nv_valid), .nv_cfg(nv_cfg), .nv_rate(nv_rate),
    .prog_failed(prog_failed), .cfg(cfg), .mrate(mrate),
    .boot_backup(boot_backup), .frame_tick(ft), .word_clock_tick(wt),
    .spdif_tx(io[7]), .opt4_adat_tx(io[6]), .spdif_coax_rx(io[5]),
    .opt_rx1(io[4]), .opt_rx2(io[3]), .opt_rx4(io[2]),
    .expansion_input_one(io[1]), .expansion_input_two(io[0]),
    .spdif_coax_out(ro[4]), .opt4_out(ro[3]), .spdif_rx(ro[2]),
    .adat1_rx(ro[1]), .adat2_rx(ro[0]));

  src_model partner (.ref_clk(ref_clk), .arst_n(arst_n), .en(en),
    .src_valid(src_valid), .src_edge(src_edge));

  // 10 MHz reference
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // one classic cycle; held until ack is sampled, released at that edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge ref_clk);
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
      @(posedge ref_clk);
    if (n == 50)
      fail_count++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string what);
    wb(1'b0, a, 32'h0);
    check(what, e, q);
  endtask : rd_chk

  // hang guard: two measurement gates plus bus traffic, with margin
  initial
  begin
    repeat (70000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    fail_count = 0;
    n_tests = 0;
    arst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {en, io, nv_valid, prog_failed} = '0;
    nv_cfg = '0;
    nv_rate = '0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    en <= 8'hff;
    repeat (2) @(posedge ref_clk);
    rd_chk(8'h00, 32'h0, "cfg reset");
    rd_chk(8'h04, 32'd48000, "mrate reset");
    rd_chk(8'h30, 32'h0, "unmapped read");
    // routing table: each write acts at once, output one cycle behind
    for (int i = 0; i < 11; i++)
    begin
      wr(8'h00, {22'h0, RCFG[i]});
      io <= RIO[i];
      repeat (2) @(posedge ref_clk);
      check("route", {27'h0, REXP[i]}, {27'h0, ro});
    end
    wr(8'h04, 32'd32000);
    rd_chk(8'h1c, 32'd32000, "sysrate master");
    wr(8'h0c, 32'd44100);
    wr(8'h10, 32'd5);
    wr(8'h14, 32'h0000fffd);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h08, {24'h0, DCTL[i]});
      rd_chk(8'h1c, DEXP[i], "synth rate");
    end
    rd_chk(8'h24, 32'd44097, "synth value");
    wr(8'h0c, 32'd48000);
    for (int p = 1; p < 5; p++)
    begin
      wr(8'h08, 32'h80 | p);
      rd_chk(8'h1c, PEXP[p-1], "preset rate");
    end
    // auto mode: synth ignored, nothing measured yet, so still master
    wr(8'h00, 32'h200);
    rd_chk(8'h1c, 32'd32000, "sysrate auto");
    repeat (2 * GATE + 100) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
      rd_chk(8'h40 + 8'(4 * i), GATE / PER[i], "measured");
    // only source 0 sits in the lock window; it becomes the reference
    wb(1'b0, 8'h18, 32'h0);
    check("status", 32'h00020002, q & 32'hffff001f);
    check("frame tick", 32'h1, {31'h0, ft});
    check("word clock", 32'h1, {31'h0, wt});
    rd_chk(8'h1c, GATE, "sysrate slave");
    // preferred source 1 is too slow, the scan falls back to source 0
    wr(8'h00, 32'h240);
    wb(1'b0, 8'h18, 32'h0);
    check("fallback", 32'h00020002, q & 32'hffff001f);
    // reference lost: straight back to master
    en <= 8'hfe;
    repeat (2) @(posedge ref_clk);
    wb(1'b0, 8'h18, 32'h0);
    check("status lost", 32'h1, q & 32'hffff0003);
    // power-up restore from the store, with a failed programming flag
    nv_valid <= 1'b1;
    nv_cfg <= 10'h009;
    nv_rate <= 20'd44100;
    prog_failed <= 1'b1;
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("cfg restore", 32'h009, {22'h0, cfg});
    check("backup boot", 32'h1, {31'h0, boot_backup});
    rd_chk(8'h1c, 32'd44100, "sysrate restore");
    report_and_stop();
  end
endmodule : tb
